// ### logic/clcl_pkg.sv
// package: register map, field layout and shared types of the closed-loop scaling block
package clcl_pkg;

  // ******************************************************************
  // register indices (printed offsets are not all multiples of four)
  // ******************************************************************
  localparam logic [7:0] IDX_UP_DELAY = 8'h18;
  localparam logic [7:0] IDX_DN_DELAY = 8'h19;
  localparam logic [7:0] IDX_MAX_GAMMA = 8'h1c;
  localparam logic [7:0] IDX_VMIN = 8'h60;
  localparam logic [7:0] IDX_VADD = 8'h61;
  localparam logic [7:0] IDX_FILT_CFG = 8'h63;
  localparam logic [7:0] IDX_VRAW = 8'h65;
  localparam logic [7:0] IDX_VFILT = 8'h66;
  localparam logic [7:0] IDX_SCALE_CFG = 8'h70;
  localparam logic [7:0] IDX_CTRL = 8'h71;
  localparam logic [7:0] IDX_STATUS = 8'h74;
  localparam int ADDR_W = 10;

  // ******************************************************************
  // field positions and reset values
  // ******************************************************************
  localparam int WAIT_LSB = 0;
  localparam int FEXP_LSB = 8;
  localparam int IMIN_LSB = 0;
  localparam int IMAX_LSB = 8;
  localparam int CTRL_CL_EN = 0;
  localparam int CTRL_SCALE_EN = 1;
  localparam int CTRL_EMF_EN = 2;
  localparam int CTRL_SERIAL = 3;
  localparam logic [7:0] MAX_GAMMA_RST = 8'hff;
  localparam logic [31:0] FILT_CFG_RST = 32'h0000_0021;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;

  // ******************************************************************
  // types
  // ******************************************************************
  typedef enum logic [1:0] {
    RAMP_IDLE = 2'b00,
    RAMP_UP = 2'b01,
    RAMP_DOWN = 2'b11
  } clcl_ramp_t;

  typedef struct packed {
    logic [7:0] min_scale;
    logic [7:0] max_scale;
    logic [31:0] rise_threshold;
    logic [31:0] max_offset;
  } clcl_scale_cfg_t;

endpackage

// ### logic/clcl_lin_map.sv
// module: piecewise linear map of a magnitude onto an output range
`timescale 1ns/1ps
module clcl_lin_map
(
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [31:0] mag, // absolute input value
  input wire logic [31:0] lo, // lower knee
  input wire logic [31:0] hi, // upper knee (>= lo)
  input wire logic [7:0] out_lo, // output at or below lo
  input wire logic [7:0] out_hi, // output above hi
  output logic [7:0] out_r // mapped output, registered
);
  logic [31:0] span;
  logic [31:0] pos;
  logic [8:0] delta;
  logic [40:0] prod;
  logic [31:0] quot;
  logic [7:0] lin;
  logic [7:0] out_nxt;

  assign span = hi - lo;
  assign pos = mag - lo;
  assign delta = {1'b0, out_hi} - {1'b0, out_lo};
  assign prod = {9'h000, pos} * {32'h0000_0000, delta};
  // a divider is costly but the map runs once per clock and must be exact
  assign quot = (span == 32'h0000_0000) ? 32'h0000_0000 : 32'(prod / {9'h000, span});
  assign lin = out_lo + quot[7:0];
  assign out_nxt = (mag <= lo) ? out_lo : (mag > hi) ? out_hi : lin;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      out_r <= 8'h00;
    else
      out_r <= out_nxt;
  end
endmodule // clcl_lin_map

// ### logic/clcl_top.sv
// module: closed-loop current scaling, load angle and encoder velocity filter
`timescale 1ns/1ps
module clcl_top
(
  input wire logic clk, // 20 MHz system clock
  input wire logic rst_n, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [9:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error for unmapped address or write to a read-only register
  input wire logic [31:0] position_deviation, // signed encoder position deviation
  input wire logic [31:0] encoder_velocity, // signed raw encoder velocity
  input wire logic [31:0] commutation_angle, // commutation angle in microsteps
  input wire logic [7:0] open_loop_scale, // scale chosen by open-loop options
  input wire logic [7:0] serial_request_period, // serial encoder request period
  output logic [7:0] applied_scale, // current scale to the driver path
  output logic [31:0] corrected_angle // commutation angle plus load angle
);
  // ******************************************************************
  // registers
  // ******************************************************************
  logic [31:0] up_delay_r;
  logic [31:0] dn_delay_r;
  logic [7:0] max_gamma_r;
  logic [31:0] vmin_r;
  logic [31:0] vadd_r;
  logic [31:0] filt_cfg_r;
  logic [31:0] scale_cfg_r;
  logic [31:0] beta_r;
  logic [31:0] startup_r;
  logic [3:0] ctrl_r;
  logic [31:0] vraw_r;
  logic [31:0] vfilt_r;
  logic [7:0] scale_r;
  logic [7:0] scale_nxt;
  logic [7:0] target_prev_r;
  logic [31:0] dly_cnt_r;
  logic [31:0] dly_cnt_nxt;
  logic [7:0] wait_cnt_r;
  clcl_pkg::clcl_ramp_t ramp_r;
  clcl_pkg::clcl_ramp_t ramp_nxt;
  clcl_pkg::clcl_scale_cfg_t scfg;

  // ******************************************************************
  // apb decode
  // ******************************************************************
  wire [7:0] idx = paddr[9:2];
  wire wr_en = psel && penable && pwrite;
  wire hit_up = (idx == clcl_pkg::IDX_UP_DELAY);
  wire hit_dn = (idx == clcl_pkg::IDX_DN_DELAY);
  wire hit_gam = (idx == clcl_pkg::IDX_MAX_GAMMA);
  wire hit_vmin = (idx == clcl_pkg::IDX_VMIN);
  wire hit_vadd = (idx == clcl_pkg::IDX_VADD);
  wire hit_filt = (idx == clcl_pkg::IDX_FILT_CFG);
  wire hit_vraw = (idx == clcl_pkg::IDX_VRAW);
  wire hit_vfilt = (idx == clcl_pkg::IDX_VFILT);
  wire hit_scfg = (idx == clcl_pkg::IDX_SCALE_CFG);
  wire hit_ctrl = (idx == clcl_pkg::IDX_CTRL);
  wire hit_stat = (idx == clcl_pkg::IDX_STATUS);
  wire hit_beta = (idx == clcl_pkg::IDX_SCALE_CFG + 8'h02);
  wire hit_start = (idx == clcl_pkg::IDX_SCALE_CFG + 8'h03);
  wire mapped = hit_up || hit_dn || hit_gam || hit_vmin || hit_vadd || hit_filt
    || hit_vraw || hit_vfilt || hit_scfg || hit_ctrl || hit_stat || hit_beta || hit_start;
  wire ro_hit = hit_vraw || hit_vfilt || hit_stat;
  wire [31:0] rd_mux =
    hit_up ? up_delay_r :
    hit_dn ? dn_delay_r :
    hit_gam ? {24'h000000, max_gamma_r} :
    hit_vmin ? vmin_r :
    hit_vadd ? vadd_r :
    hit_filt ? {20'h00000, filt_cfg_r[11:0]} :
    hit_vraw ? vraw_r :
    hit_vfilt ? vfilt_r :
    hit_scfg ? {16'h0000, scale_cfg_r[15:0]} :
    hit_ctrl ? {28'h0000000, ctrl_r} :
    hit_beta ? beta_r :
    hit_start ? startup_r :
    hit_stat ? {22'h000000, ramp_r, scale_r} : clcl_pkg::ZERO32;

  // zero wait states: every access finishes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && (!mapped || (pwrite && ro_hit));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prdata <= clcl_pkg::ZERO32;
    else if (psel && !penable && !pwrite)
      prdata <= rd_mux;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      up_delay_r <= clcl_pkg::ZERO32;
      dn_delay_r <= clcl_pkg::ZERO32;
      max_gamma_r <= clcl_pkg::MAX_GAMMA_RST;
      vmin_r <= clcl_pkg::ZERO32;
      vadd_r <= clcl_pkg::ZERO32;
      filt_cfg_r <= clcl_pkg::FILT_CFG_RST;
      scale_cfg_r <= clcl_pkg::ZERO32;
      beta_r <= clcl_pkg::ZERO32;
      startup_r <= clcl_pkg::ZERO32;
      ctrl_r <= 4'h0;
    end
    else if (wr_en)
    begin
      if (hit_up) up_delay_r <= pwdata;
      if (hit_dn) dn_delay_r <= pwdata;
      if (hit_gam) max_gamma_r <= pwdata[7:0];
      if (hit_vmin) vmin_r <= pwdata;
      if (hit_vadd) vadd_r <= pwdata;
      if (hit_filt) filt_cfg_r <= pwdata;
      if (hit_scfg) scale_cfg_r <= pwdata;
      if (hit_beta) beta_r <= pwdata;
      if (hit_start) startup_r <= pwdata;
      if (hit_ctrl) ctrl_r <= pwdata[3:0];
    end
  end

  // ******************************************************************
  // control bits
  // ******************************************************************
  wire cl_en = ctrl_r[clcl_pkg::CTRL_CL_EN];
  wire scale_en = ctrl_r[clcl_pkg::CTRL_SCALE_EN];
  wire emf_en = ctrl_r[clcl_pkg::CTRL_EMF_EN];
  wire serial_enc = ctrl_r[clcl_pkg::CTRL_SERIAL];

  assign scfg.min_scale = scale_cfg_r[clcl_pkg::IMIN_LSB +: 8];
  assign scfg.max_scale = scale_cfg_r[clcl_pkg::IMAX_LSB +: 8];
  assign scfg.rise_threshold = startup_r;
  assign scfg.max_offset = (beta_r < startup_r) ? startup_r : beta_r;

  // ******************************************************************
  // target scale from position deviation
  // ******************************************************************
  wire [31:0] dev_abs = position_deviation[31] ? 32'(-position_deviation) : position_deviation;
  logic [7:0] target;

  clcl_lin_map u_scale_map
  (
    .clk(clk),
    .rst_n(rst_n),
    .mag(dev_abs),
    .lo(scfg.rise_threshold),
    .hi(scfg.max_offset),
    .out_lo(scfg.min_scale),
    .out_hi(scfg.max_scale),
    .out_r(target)
  );

  // ******************************************************************
  // applied scale stepping
  // ******************************************************************
  wire tgt_chg = (target != target_prev_r);
  wire going_up = (target > scale_r);
  wire going_dn = (target < scale_r);
  wire [31:0] cur_delay = going_up ? up_delay_r : dn_delay_r;
  wire dly_done = (dly_cnt_r + 32'h0000_0001 >= cur_delay);

  always_comb
  begin
    scale_nxt = scale_r;
    dly_cnt_nxt = 32'h0000_0000;
    ramp_nxt = clcl_pkg::RAMP_IDLE;
    if (going_up && up_delay_r == clcl_pkg::ZERO32)
      scale_nxt = target;
    else if (going_dn && dn_delay_r == clcl_pkg::ZERO32)
      scale_nxt = target;
    else if (going_up || going_dn)
    begin
      ramp_nxt = going_up ? clcl_pkg::RAMP_UP : clcl_pkg::RAMP_DOWN;
      if (tgt_chg)
        dly_cnt_nxt = 32'h0000_0000;
      else if (dly_done)
        scale_nxt = going_up ? scale_r + 8'h01 : scale_r - 8'h01;
      else
        dly_cnt_nxt = dly_cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scale_r <= 8'h00;
      target_prev_r <= 8'h00;
      dly_cnt_r <= clcl_pkg::ZERO32;
      ramp_r <= clcl_pkg::RAMP_IDLE;
    end
    else
    begin
      scale_r <= scale_nxt;
      target_prev_r <= target;
      dly_cnt_r <= dly_cnt_nxt;
      ramp_r <= ramp_nxt;
    end
  end

  // ******************************************************************
  // encoder velocity sampling and filter
  // ******************************************************************
  wire [7:0] wait_len = serial_enc ? serial_request_period
    : filt_cfg_r[clcl_pkg::WAIT_LSB +: 8];
  wire [3:0] fexp = filt_cfg_r[clcl_pkg::FEXP_LSB +: 4];
  wire sample = (wait_cnt_r + 8'h01 >= wait_len);
  // shifts stand alone so the unsigned sum cannot turn them into logical shifts
  wire signed [31:0] vfilt_shr = $signed(vfilt_r) >>> fexp;
  wire signed [31:0] vraw_shr = $signed(vraw_r) >>> fexp;
  wire [31:0] vfilt_nxt = vfilt_r - vfilt_shr + vraw_shr;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vraw_r <= clcl_pkg::ZERO32;
      vfilt_r <= clcl_pkg::ZERO32;
      wait_cnt_r <= 8'h00;
    end
    else
    begin
      vraw_r <= encoder_velocity;
      wait_cnt_r <= sample ? 8'h00 : wait_cnt_r + 8'h01;
      if (sample)
        vfilt_r <= vfilt_nxt;
    end
  end

  // ******************************************************************
  // load angle
  // ******************************************************************
  wire [31:0] vf_abs = vfilt_r[31] ? 32'(-vfilt_r) : vfilt_r;
  wire [31:0] vtop = vmin_r + vadd_r;
  logic [7:0] gamma;

  clcl_lin_map u_gamma_map
  (
    .clk(clk),
    .rst_n(rst_n),
    .mag(vf_abs),
    .lo(vmin_r),
    .hi((vtop < vmin_r) ? 32'hffff_ffff : vtop),
    .out_lo(8'h00),
    .out_hi(max_gamma_r),
    .out_r(gamma)
  );

  // beta plus gamma staying under 511 is left to software
  wire emf_on = cl_en && emf_en;
  wire [31:0] gamma_ext = {24'h000000, gamma};
  wire [31:0] angle_nxt = !emf_on ? commutation_angle
    : vfilt_r[31] ? commutation_angle - gamma_ext
    : commutation_angle + gamma_ext;
  wire [7:0] scale_out = (cl_en && scale_en) ? scale_r : open_loop_scale;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      applied_scale <= 8'h00;
      corrected_angle <= clcl_pkg::ZERO32;
    end
    else
    begin
      applied_scale <= scale_out;
      corrected_angle <= angle_nxt;
    end
  end
endmodule // clcl_top

// ### tb/clcl_enc_model.sv
// partner model: encoder front end presenting deviation and measured velocity
`timescale 1ns/1ps
module clcl_enc_model
(
  input wire logic clk, // system clock
  input wire logic rst_n, // reset, active low
  input wire logic [31:0] dev_cmd, // deviation to present
  input wire logic [31:0] vel_cmd, // velocity to present
  output logic [31:0] position_deviation, // to the block
  output logic [31:0] encoder_velocity // to the block
);
  // ****
  // registered outputs, changing just after an edge
  // ****
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      position_deviation <= 32'h0;
      encoder_velocity <= 32'h0;
    end
    else
    begin
      position_deviation <= dev_cmd;
      encoder_velocity <= vel_cmd;
    end
endmodule // clcl_enc_model

// ### tb/clcl_properties.sv
// checker: port-level properties of the closed-loop scaling block
`timescale 1ns/1ps
module clcl_properties
(
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic psel, // apb
  input wire logic penable, // apb
  input wire logic pwrite, // apb
  input wire logic [9:0] paddr, // apb
  input wire logic [31:0] pwdata, // apb
  input wire logic [31:0] prdata, // apb
  input wire logic pready, // apb
  input wire logic pslverr, // apb
  input wire logic [7:0] open_loop_scale, // scale in
  input wire logic [31:0] commutation_angle, // angle in
  input wire logic [7:0] applied_scale, // scale out
  input wire logic [31:0] corrected_angle // angle out
);
  // ****
  // shadow of control and delay registers
  // ****
  logic [3:0] ctrl_r;
  logic up_nz_r;
  logic dn_nz_r;
  logic g_wr_r;
  wire wr = psel && penable && pwrite && pready;
  wire [7:0] idx = paddr[9:2];
  wire sc_on = ctrl_r[0] && ctrl_r[1];
  wire ang_off = !(ctrl_r[0] && ctrl_r[2]);
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      ctrl_r <= 4'h0;
      up_nz_r <= 1'b0;
      dn_nz_r <= 1'b0;
      g_wr_r <= 1'b0;
    end
    else if (wr)
    begin
      if (idx == 8'h71) ctrl_r <= pwdata[3:0];
      if (idx == 8'h18) up_nz_r <= (pwdata != 32'h0);
      if (idx == 8'h19) dn_nz_r <= (pwdata != 32'h0);
      if (idx == 8'h1c) g_wr_r <= 1'b1;
    end
  // ****
  // properties
  // ****
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  AST_RO_RAW: assert property (wr && idx == 8'h65 |-> pslverr)
    else $error("raw velocity write accepted");
  AST_RO_FILT: assert property (wr && idx == 8'h66 |-> pslverr)
    else $error("filtered velocity write accepted");
  AST_CFG_OK: assert property (wr && idx == 8'h63 |-> !pslverr)
    else $error("filter config write refused");
  AST_GAMMA_RST: assert property (psel && penable && !pwrite && idx == 8'h1c && !g_wr_r
    |-> prdata == 32'h0000_00ff)
    else $error("max load angle not at reset value");
  AST_OPEN_LOOP: assert property ((!sc_on && $stable(open_loop_scale))[*3]
    |-> applied_scale == open_loop_scale)
    else $error("open-loop scale not passed");
  AST_UP_STEP: assert property (sc_on && $past(sc_on) && $past(sc_on, 2) && up_nz_r
    && $past(up_nz_r)
    |-> {1'b0, applied_scale} <= {1'b0, $past(applied_scale)} + 9'h001)
    else $error("scale rose by more than one step");
  AST_DN_STEP: assert property (sc_on && $past(sc_on) && $past(sc_on, 2) && dn_nz_r
    && $past(dn_nz_r)
    |-> {1'b0, applied_scale} + 9'h001 >= {1'b0, $past(applied_scale)})
    else $error("scale fell by more than one step");
  AST_EMF_OFF: assert property ($past(rst_n) && ang_off && $past(ang_off)
    |-> corrected_angle == $past(commutation_angle))
    else $error("angle changed without back-emf");
  COV_UP: cover property (sc_on && applied_scale > $past(applied_scale));
  COV_EMF: cover property (!ang_off && corrected_angle != commutation_angle);
  COV_ERR: cover property (pslverr);
endmodule // clcl_properties

bind clcl_top clcl_properties u_props (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .open_loop_scale(open_loop_scale),
  .commutation_angle(commutation_angle), .applied_scale(applied_scale),
  .corrected_angle(corrected_angle));

// ### tb/test_closed_loop_current_and_load_angle.sv
// testbench: closed-loop scaling block against a behavioural model
`timescale 1ns/1ps
module test_closed_loop_current_and_load_angle;
  // ****
  // signals and instances
  // ****
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] dev_cmd = 32'h0;
  logic [31:0] vel_cmd = 32'h0;
  logic [31:0] commutation_angle = 32'h0;
  logic [7:0] open_loop_scale = 8'h0;
  logic [7:0] serial_request_period = 8'h28;
  logic [31:0] prdata, position_deviation, encoder_velocity, corrected_angle, rd;
  logic [7:0] applied_scale;
  logic pready, pslverr, err;
  int n_errors = 0;
  int checked = 0;
  always #25 clk = ~clk;
  clcl_top uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .position_deviation(position_deviation), .encoder_velocity(encoder_velocity),
    .commutation_angle(commutation_angle), .open_loop_scale(open_loop_scale),
    .serial_request_period(serial_request_period), .applied_scale(applied_scale),
    .corrected_angle(corrected_angle));
  clcl_enc_model enc (.clk(clk), .rst_n(rst_n), .dev_cmd(dev_cmd), .vel_cmd(vel_cmd),
    .position_deviation(position_deviation), .encoder_velocity(encoder_velocity));
  // ****
  // model, bus and compare tasks
  // ****
  function automatic int exp_map(int v, int lo, int hi, int ylo, int yhi);
    int a = v < 0 ? -v : v;
    return a <= lo ? ylo : (a > hi ? yhi : -1); // -1: above lo and at or below hi
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_in(input logic [31:0] got, input int lo, input int hi, input string what);
    checked++;
    if (!(got >= lo && got <= hi) || $isunknown(got))
    begin
      n_errors++;
      $display("wrong value at %0t: %s got %0d", $time, what, got);
    end
  endtask
  task automatic stall();
    n_errors++;
    wrap_up();
  endtask
  // an idle cycle before each setup keeps every signal to one update per edge
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20) stall();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp, input string what);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp, what);
  endtask
  task automatic wait_scale(input logic [7:0] want, output int cyc);
    cyc = 0;
    while (applied_scale !== want && cyc < 400)
    begin
      @(posedge clk);
      cyc++;
    end
    if (cyc >= 400) stall();
  endtask
  // ****
  // scenarios
  // ****
  initial
  begin
    int e, cyc, r;
    int devs[6] = '{32'h0, -32'sh64, 32'h96, 32'hc9, -32'sh1388, 32'h3};
    int vels[3] = '{32'h3e8, -32'sh3e8, 32'h32};
    void'($urandom(32'h488f));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(8'h1c, 32'h0000_00ff, "gamma reset");
    rdchk(8'h63, 32'h0000_0021, "filter reset");
    for (int i = 0; i < 2; i++)
    begin
      r = $urandom;
      apb(1'b1, 8'h18 + 8'(i), r);
      rdchk(8'h18 + 8'(i), r, "delay reg");
    end
    apb(1'b1, 8'h65, 32'h5);
    chk({31'h0, err}, 32'h1, "ro write");
    apb(1'b1, 8'h66, 32'h5);
    chk({31'h0, err}, 32'h1, "ro filt write");
    rdchk(8'h10, 32'h0, "unmapped");
    chk({31'h0, err}, 32'h1, "unmapped err");
    $display("test done: registers");
    r = $urandom & 32'h000f_fffe;
    vel_cmd <= r;
    apb(1'b1, 8'h63, 32'h0000_0121);
    repeat (1400) @(posedge clk);
    rdchk(8'h66, r, "filter exp1");
    r = $urandom;
    vel_cmd <= r;
    apb(1'b1, 8'h63, 32'h0000_00ff);
    serial_request_period <= 8'h10;
    apb(1'b1, 8'h71, 32'h8);
    repeat (24) @(posedge clk);
    rdchk(8'h66, r, "serial filter");
    rdchk(8'h65, r, "raw velocity");
    apb(1'b1, 8'h63, 32'h0000_0021);
    $display("test done: velocity");
    apb(1'b1, 8'h70, 32'h0000_320a);
    apb(1'b1, 8'h72, 32'hc8);
    chk({31'h0, err}, 32'h0, "beta write");
    apb(1'b1, 8'h73, 32'h64);
    apb(1'b1, 8'h18, 32'h0);
    apb(1'b1, 8'h19, 32'h0);
    apb(1'b1, 8'h71, 32'h3);
    foreach (devs[i])
    begin
      dev_cmd <= devs[i];
      open_loop_scale <= 8'($urandom);
      repeat (5) @(posedge clk);
      e = exp_map(devs[i], 32'h64, 32'hc8, 32'h0a, 32'h32);
      if (e < 0) chk_in({24'h0, applied_scale}, 32'h0b, 32'h31, "mid scale");
      else chk({24'h0, applied_scale}, e, "scale jump");
    end
    dev_cmd <= 32'h0;
    apb(1'b1, 8'h18, 32'h4);
    apb(1'b1, 8'h19, 32'h2);
    wait_scale(8'h0a, cyc);
    dev_cmd <= 32'h3e8;
    wait_scale(8'h32, cyc);
    chk_in(cyc, 32'h9a, 32'haa, "up ramp");
    rdchk(8'h74, 32'h0000_0032, "status idle");
    dev_cmd <= 32'h0;
    wait_scale(8'h0a, cyc);
    chk_in(cyc, 32'h4c, 32'h56, "down ramp");
    $display("test done: scaling");
    commutation_angle <= 32'h1388;
    apb(1'b1, 8'h1c, 32'h40);
    apb(1'b1, 8'h60, 32'h64);
    apb(1'b1, 8'h61, 32'h64);
    apb(1'b1, 8'h71, 32'h7);
    foreach (vels[i])
    begin
      vel_cmd <= vels[i];
      repeat (45) @(posedge clk);
      e = exp_map(vels[i], 32'h64, 32'hc8, 32'h0, 32'h40);
      chk(corrected_angle, 32'h1388 + (vels[i] < 0 ? -e : e), "load angle");
    end
    vel_cmd <= 32'h96;
    repeat (45) @(posedge clk);
    chk_in(corrected_angle, 32'h1389, 32'h13c7, "mid load angle");
    apb(1'b1, 8'h71, 32'h3);
    repeat (3) @(posedge clk);
    chk(corrected_angle, 32'h1388, "emf off");
    apb(1'b1, 8'h71, 32'h6);
    repeat (5) @(posedge clk);
    chk({24'h0, applied_scale}, {24'h0, open_loop_scale}, "loop off");
    $display("test done: load angle");
    wrap_up();
  end
  initial
  begin
    repeat (100000) @(posedge clk);
    stall();
  end
endmodule // test_closed_loop_current_and_load_angle
